// ---- rtl/watchdog_params.svh ----
// Constants for the one-time-enabled software upset guard timer.
// Assumes it is included by bare name from the package and the design module.
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH

// Special function address of the write-only restart key register
`define WDG_RESTART_ADDR 8'ha6
// Key values, first then second
`define WDG_KEY_FIRST    8'h1e
`define WDG_KEY_SECOND   8'he1
// Counter width and terminal value
`define WDG_COUNT_W      14
`define WDG_COUNT_MAX    14'h3fff
`define WDG_COUNT_ZERO   14'h0000
`define WDG_COUNT_ONE    14'h0001
// Oscillator periods per machine cycle
`define WDG_MC_SIX       4'h6
`define WDG_MC_TWELVE    4'hc
`define WDG_MC_ZERO      4'h0
`define WDG_MC_ONE       4'h1
// Outgoing reset pulse length in oscillator periods (98 and 196)
`define WDG_PULSE_SIX    8'h62
`define WDG_PULSE_TWELVE 8'hc4
`define WDG_PULSE_ZERO   8'h00
`define WDG_PULSE_ONE    8'h01

`endif

// ---- rtl/watchdog_pkg.sv ----
// Types shared by the software upset guard timer and its surroundings.
// Assumes the constants header sits beside this file.
`include "watchdog_params.svh"

package watchdog_pkg;

	// Count state of the guard timer
	typedef logic [`WDG_COUNT_W-1:0] wdg_count_t;

	// Key sequence tracker
	typedef enum logic [0:0]
	{
		KEY_IDLE,
		KEY_GOT_FIRST
	} key_state_e;

	// One write on the special function register bus
	typedef struct packed
	{
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} sfr_write_s;

endpackage

// ---- rtl/software_upset_guard_timer.sv ----
// Software upset guard timer: a one-time-enabled 14-bit machine-cycle watchdog
// with an outgoing reset pulse. Assumes clk_sys is the oscillator itself, that
// the CPU's special function register writes arrive on the same clock, and that
// the chip reset tree feeds rst_b (hardware reset) and consumes device_reset_req.
`timescale 1ns/10ps
`include "watchdog_params.svh"

// Overview of operation
// - Disarmed and not counting after any reset
// - Arms only on 01EH then 0E1H at 0A6H
// - Count state is a 14-bit counter
// - Counts machine cycles only while oscillator runs
// - Once armed, only reset disarms it
// - Key pair while armed clears the counter
// - Reaching 3FFFH overflows and resets device
// - Overflow drives reset pin high outward
// - Pulse lasts 98 or 196 oscillator periods
// - Register write only; counter never accessible
module software_upset_guard_timer
(
	// Clock and hardware reset
	input  wire logic                    clk_sys,
	input  wire logic                    rst_b,
	// Special function register write bus from the CPU
	input  wire watchdog_pkg::sfr_write_s sfr_wr,
	// Clock control
	input  wire logic                    six_clock_mode,
	input  wire logic                    osc_running,
	// Reset pin drive and internal reset request
	output logic                         reset_pin_out,
	output logic                         reset_pin_oe,
	output logic                         device_reset_req
);
	import watchdog_pkg::*;

	// Oscillator periods in one machine cycle for the selected mode
	function automatic logic [3:0] mc_len(input logic six);
		mc_len = six ? `WDG_MC_SIX : `WDG_MC_TWELVE;
	endfunction

	// Outgoing pulse length for the selected mode
	function automatic logic [7:0] pulse_len(input logic six);
		pulse_len = six ? `WDG_PULSE_SIX : `WDG_PULSE_TWELVE;
	endfunction

	key_state_e  key_state;        // Key sequence progress
	key_state_e  next_key_state;
	logic        armed;            // Set once enabled, cleared only by reset
	logic        next_armed;
	wdg_count_t  count;            // Machine cycle count, never visible to software
	wdg_count_t  next_count;
	logic [3:0]  prescale;         // Oscillator periods within the machine cycle
	logic [3:0]  next_prescale;
	logic [7:0]  pulse_cnt;        // Remaining periods of the outgoing pulse
	logic [7:0]  next_pulse_cnt;
	logic        next_pulse_on;
	logic [7:0]  pulse_hold;       // Length chosen at overflow, for checking
	logic [7:0]  next_pulse_hold;

	logic        restart_wr;       // Write to the restart key register
	logic        key_pair_done;    // Second key right after the first
	logic        mc_tick;          // One oscillator period per machine cycle
	logic        overflow;         // Armed counter at its terminal value
	logic        in_pulse;         // Device held in reset by our own pulse

	// Address decode; there is deliberately no read path at all
	assign restart_wr    = sfr_wr.wr && (sfr_wr.addr == `WDG_RESTART_ADDR);
	assign in_pulse      = (pulse_cnt != `WDG_PULSE_ZERO);
	assign key_pair_done = restart_wr && !in_pulse && (key_state == KEY_GOT_FIRST)
	                       && (sfr_wr.data == `WDG_KEY_SECOND);
	// Machine cycle strobe follows the selected clock mode
	assign mc_tick       = osc_running && (prescale == mc_len(six_clock_mode) - `WDG_MC_ONE);
	assign overflow      = armed && (count == `WDG_COUNT_MAX);

	// Key sequence: any value other than the two keys on the second write drops the sequence
	always_comb
	begin
		next_key_state = key_state;
		if (in_pulse)
		begin
			// Writes made while the device is in reset are ignored
			next_key_state = KEY_IDLE;
		end
		else if (restart_wr)
		begin
			// A fresh first key always restarts the sequence
			if (sfr_wr.data == `WDG_KEY_FIRST)
				next_key_state = KEY_GOT_FIRST;
			else
				next_key_state = KEY_IDLE;
		end
	end

	// Key state register
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			key_state <= KEY_IDLE;
		else
			key_state <= next_key_state;
	end

	// Prescaler, counter, arm flag and overflow pulse
	always_comb
	begin
		next_prescale   = prescale;
		next_count      = count;
		next_armed      = armed;
		next_pulse_cnt  = pulse_cnt;
		next_pulse_hold = pulse_hold;
		// Prescaler halts with the oscillator; after a mode change it wraps to zero only if already at or past the new length
		if (!osc_running)
			next_prescale = prescale;
		else if (mc_tick || (prescale >= mc_len(six_clock_mode)))
			next_prescale = `WDG_MC_ZERO;
		else
			next_prescale = prescale + `WDG_MC_ONE;
		if (overflow)
		begin
			// Own overflow reset: disarm, clear and start the pin pulse
			next_armed      = 1'b0;
			next_count      = `WDG_COUNT_ZERO;
			next_pulse_cnt  = pulse_len(six_clock_mode);
			next_pulse_hold = pulse_len(six_clock_mode);
			next_prescale   = `WDG_MC_ZERO;
		end
		else if (in_pulse)
		begin
			// Count down the pulse; the device stays disarmed meanwhile
			next_pulse_cnt = pulse_cnt - `WDG_PULSE_ONE;
			next_count     = `WDG_COUNT_ZERO;
			next_prescale  = `WDG_MC_ZERO;
		end
		else if (key_pair_done)
		begin
			// Key pair arms when idle, services when armed
			next_armed = 1'b1;
			next_count = `WDG_COUNT_ZERO;
		end
		else if (armed && mc_tick)
		begin
			// One step per machine cycle in the 14-bit counter
			next_count = count + `WDG_COUNT_ONE;
		end
		// No path here ever clears the arm flag except overflow
		next_pulse_on = (next_pulse_cnt != `WDG_PULSE_ZERO);
	end

	// Registers; async reset leaves the timer disarmed and idle
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prescale         <= `WDG_MC_ZERO;
			count            <= `WDG_COUNT_ZERO;
			armed            <= 1'b0;
			pulse_cnt        <= `WDG_PULSE_ZERO;
			pulse_hold       <= `WDG_PULSE_ZERO;
			reset_pin_out    <= 1'b0;
			reset_pin_oe     <= 1'b0;
			device_reset_req <= 1'b0;
		end
		else
		begin
			prescale         <= next_prescale;
			count            <= next_count;
			armed            <= next_armed;
			pulse_cnt        <= next_pulse_cnt;
			pulse_hold       <= next_pulse_hold;
			reset_pin_out    <= next_pulse_on;
			reset_pin_oe     <= next_pulse_on;
			device_reset_req <= next_pulse_on;
		end
	end

	// Helper: length of the current pin pulse, read only by the checks below
	logic [7:0] pulse_seen;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			pulse_seen <= `WDG_PULSE_ZERO;
		else if (reset_pin_oe)
			pulse_seen <= pulse_seen + `WDG_PULSE_ONE;
		else
			pulse_seen <= `WDG_PULSE_ZERO;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// Disarmed timer never holds a count
	property p_idle_no_count;
		!armed |-> count == `WDG_COUNT_ZERO;
	endproperty
	a_idle_no_count: assert property (p_idle_no_count) else $error("count nonzero while disarmed");

	// Arming only follows the two keys in order
	property p_arm_by_keys;
		$rose(armed) |-> $past(key_state) == KEY_GOT_FIRST && $past(restart_wr)
		                 && $past(sfr_wr.data) == `WDG_KEY_SECOND;
	endproperty
	a_arm_by_keys: assert property (p_arm_by_keys) else $error("armed without key pair");

	// Armed counter steps by one per machine cycle
	property p_count_step;
		armed && mc_tick && !overflow && !key_pair_done |=> count == $past(count) + `WDG_COUNT_ONE;
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter failed to step");

	// Stopped oscillator freezes the count
	property p_hold_stopped;
		armed && !osc_running && !overflow && !key_pair_done |=> $stable(count);
	endproperty
	a_hold_stopped: assert property (p_hold_stopped) else $error("count moved with oscillator stopped");

	// Nothing but overflow disarms
	property p_stays_armed;
		armed && !overflow |=> armed;
	endproperty
	a_stays_armed: assert property (p_stays_armed) else $error("watchdog disarmed without reset");

	// Key pair while armed clears the counter
	property p_service;
		armed && !overflow && key_pair_done |=> armed && count == `WDG_COUNT_ZERO;
	endproperty
	a_service: assert property (p_service) else $error("service did not clear counter");

	// Terminal count drives the pin and the internal reset next cycle
	property p_overflow;
		armed && count == `WDG_COUNT_MAX |=> reset_pin_oe && reset_pin_out && device_reset_req && !armed;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow did not reset");

	// Pulse length matches the mode chosen at overflow
	property p_pulse_len;
		$fell(reset_pin_oe) |-> $past(pulse_seen) == pulse_hold - `WDG_PULSE_ONE;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("reset pulse wrong length");

	// A wrong second key drops the sequence unless it is the first key again
	property p_lone_first;
		key_state == KEY_GOT_FIRST && restart_wr && sfr_wr.data != `WDG_KEY_SECOND && !in_pulse
		|=> key_state != KEY_GOT_FIRST || $past(sfr_wr.data) == `WDG_KEY_FIRST;
	endproperty
	a_lone_first: assert property (p_lone_first) else $error("bad key kept sequence");

	// Machine cycle strobes are spaced six periods apart in 6-clock mode
	property p_mc_spacing;
		mc_tick && six_clock_mode ##1 (six_clock_mode && osc_running && !overflow && !in_pulse)[*6] |-> mc_tick;
	endproperty
	a_mc_spacing: assert property (p_mc_spacing) else $error("machine cycle spacing wrong");

endmodule // software_upset_guard_timer

// ---- verification/software_upset_guard_timer_tb.sv ----
// Self-checking bench for the software upset guard timer, run mainly in 6-clock mode.
// Assumes the watchdog package and constants header are compiled before it.
`timescale 1ns/10ps

module software_upset_guard_timer_tb;
	import watchdog_pkg::*;

	// 12-clock mode overflow would double the run, so only a short 12-clock stretch is timed
	localparam int SPAN         = 16383 * 6;
	localparam int FREEZE       = 400;
	// Ten machine cycles in 12-clock mode; the stretch ends right on a strobe
	localparam int TWELVE_LEN   = 116;
	localparam int TWELVE_EXTRA = 60;
	localparam int DUE          = SPAN + FREEZE + TWELVE_EXTRA;

	logic       clk_sys;          // Oscillator clock
	logic       rst_b;            // Hardware reset
	sfr_write_s sfr_wr;           // Register write bus
	logic       six_clock_mode;   // Mode select
	logic       osc_running;      // Oscillator run level
	logic       reset_pin_out;    // Reset pin level
	logic       reset_pin_oe;     // Reset pin drive enable
	logic       device_reset_req; // Internal reset request
	int         bad_count;        // Mismatches seen
	int         checks;           // Comparisons made
	time        t_start;          // Edge of the last service
	int         span;             // Cycles from service to pulse
	int         width;            // Pulse length in cycles

	software_upset_guard_timer software_upset_guard_timer_i
	(
		.clk_sys          (clk_sys),
		.rst_b            (rst_b),
		.sfr_wr           (sfr_wr),
		.six_clock_mode   (six_clock_mode),
		.osc_running      (osc_running),
		.reset_pin_out    (reset_pin_out),
		.reset_pin_oe     (reset_pin_oe),
		.device_reset_req (device_reset_req)
	);

	// Oscillator, 40 ns period
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// One counted comparison
	task automatic chk(input logic act, input logic exp, input string msg);
		checks++;
		if (act !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	// All reset outputs idle
	task automatic chk_idle(input string msg);
		chk(reset_pin_out, 1'b0, msg);
		chk(reset_pin_oe, 1'b0, msg);
		chk(device_reset_req, 1'b0, msg);
	endtask

	// Let cycles pass; any pulse in between is a mismatch
	task automatic wait_quiet(input int n, input string msg);
		logic seen;
		seen = 1'b0;
		repeat (n)
		begin
			@(posedge clk_sys);
			#1;
			if (reset_pin_out !== 1'b0 || reset_pin_oe !== 1'b0)
				seen = 1'b1;
		end
		chk(seen, 1'b0, msg);
	endtask

	// One register write; strobe stands for one edge, then a gap edge
	task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_sys);
		sfr_wr <= '{wr: 1'b1, addr: addr, data: data};
		@(posedge clk_sys);
		sfr_wr <= '0;
	endtask

	// Full key sequence to the restart register
	task automatic key_pair();
		wr_reg(8'ha6, 8'h1e);
		wr_reg(8'ha6, 8'he1);
	endtask

	// Single place where the run ends
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		bad_count = 0;
		checks = 0;
		rst_b = 1'b0;
		sfr_wr = '0;
		six_clock_mode = 1'b1;
		osc_running = 1'b1;
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		#1;
		chk_idle("outputs active after reset");
		wait_quiet(50, "pulse while disarmed");
		key_pair();
		wait_quiet(200, "pulse right after arming");
		key_pair();
		t_start = $time;
		wait_quiet(5000, "pulse after service");
		// Broken sequence must not service; the break value must not stop it
		wr_reg(8'ha6, 8'h1e);
		wr_reg(8'ha6, 8'h00);
		wr_reg(8'ha6, 8'he1);
		wr_reg(8'h8e, 8'h00);
		// Stopped oscillator holds the count
		osc_running <= 1'b0;
		wait_quiet(FREEZE, "pulse while oscillator stopped");
		@(posedge clk_sys);
		osc_running <= 1'b1;
		// Slower machine cycles for a while; each one costs six extra oscillator periods
		six_clock_mode <= 1'b0;
		repeat (TWELVE_LEN) @(posedge clk_sys);
		six_clock_mode <= 1'b1;
		span = 0;
		while (reset_pin_out !== 1'b1 && span < DUE + 200)
		begin
			@(posedge clk_sys);
			#1;
			span = int'(($time - t_start) / 40);
		end
		chk(logic'(span >= DUE - 4 && span <= DUE + 12), 1'b1, "overflow time");
		chk(reset_pin_oe, 1'b1, "pin not driven on overflow");
		chk(device_reset_req, 1'b1, "no internal reset on overflow");
		width = 0;
		while (reset_pin_out === 1'b1 && reset_pin_oe === 1'b1 && device_reset_req === 1'b1 && width < 400)
		begin
			width++;
			@(posedge clk_sys);
			#1;
		end
		chk(logic'(width == 98), 1'b1, "pulse length");
		chk_idle("outputs after pulse");
		wait_quiet(400, "second pulse after overflow reset");
		tally_and_finish();
	end

	// Hang guard, a little beyond the expected run
	initial
	begin
		#(40 * 115000);
		bad_count++;
		$display("CHECK FAILED at %0t: run did not finish", $time);
		tally_and_finish();
	end

endmodule // software_upset_guard_timer_tb
